// [hdl/lmac_pkg.sv]
package lmac_pkg;

  // Address counter geometry
  localparam int ADDR_W = 11;
  localparam logic [10:0] ADDR_ZERO = 11'h000;
  localparam logic [10:0] ADDR_STEP = 11'h001;
  localparam logic [10:0] ADDR_TOP = 11'h7FF;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_STRETCH = 3'b000,
    MODE_WRAP = 3'b001,
    MODE_DOUBLE = 3'b010,
    MODE_PAIR = 3'b011,
    MODE_DELAY = 3'b100
  } lmac_mode_t;

  // Write inhibit addresses per mode
  localparam logic [10:0] INHIBIT_STRETCH = 11'h7FF;
  localparam logic [10:0] INHIBIT_DOUBLE = 11'h7FF;
  localparam logic [10:0] INHIBIT_PAIR = 11'h3FF;

  // Read address lead when the delay select is low
  localparam logic [10:0] SELECT_LOW_LEAD = 11'h005;

  // Decoder slots
  localparam int DEC_N = 6;
  localparam int DEC_WWRAP = 0;
  localparam int DEC_RWRAP = 1;
  localparam int DEC_TAP1 = 2;
  localparam int DEC_TAP2 = 3;
  localparam int DEC_TAP3 = 4;
  localparam int DEC_TAP4 = 5;

  // Latch addresses, one below each target (first and second target)
  localparam logic [10:0] DEC_LATCH_A [DEC_N] = '{
    11'h7FE, 11'h7FE, 11'h383, 11'h38C, 11'h46D, 11'h464
  };
  localparam logic [10:0] DEC_LATCH_B [DEC_N] = '{
    11'h7FE, 11'h7FE, 11'h711, 11'h71A, 11'h46D, 11'h464
  };

  // Slot looks at the write counter when its bit is set
  localparam logic [DEC_N-1:0] DEC_SRC_WRITE = 6'h01;
  // Slots active per mode
  localparam logic [DEC_N-1:0] DEC_ON_WRAP = 6'h03;
  localparam logic [DEC_N-1:0] DEC_ON_DELAY = 6'h3C;
  localparam logic [DEC_N-1:0] DEC_ON_PAIR = 6'h0C;

  // Reset values
  localparam logic [DEC_N-1:0] DEC_IDLE = 6'h3F;
  localparam logic CLEAR_LEVEL_RST = 1'b0;

endpackage

// [hdl/lmac_clear_catch.sv]
`timescale 1ns/1ps
module lmac_clear_catch import lmac_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Counter step and clear level
  input wire logic tick,
  input wire logic level_n,
  input wire logic allow,
  // One-cycle clear request
  output logic fire
);

  logic level_reg;

  // Level seen at the previous counter step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_reg <= CLEAR_LEVEL_RST;
    end else if (tick) begin
      level_reg <= level_n;
    end
  end

  // Fires on a high step followed by a low step, once per fall
  assign fire = tick & allow & level_reg & ~level_n;

endmodule // lmac_clear_catch

// [hdl/lmac_addr_counter.sv]
`timescale 1ns/1ps
module lmac_addr_counter import lmac_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Step controls
  input wire logic tick,
  input wire logic advance,
  input wire logic clear,
  // Current address
  output logic [ADDR_W-1:0] addr
);

  logic [ADDR_W-1:0] addr_reg;

  // Clear beats advance; top address rolls over to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= ADDR_ZERO;
    end else if (tick) begin
      if (clear) begin
        addr_reg <= ADDR_ZERO;
      end else if (advance) begin
        addr_reg <= addr_reg + ADDR_STEP;
      end
    end
  end

  assign addr = addr_reg;

endmodule // lmac_addr_counter

// [hdl/lmac_line_memory_ctrl.sv]
`timescale 1ns/1ps
module lmac_line_memory_ctrl import lmac_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Mode straps and delay select
  input wire logic stretch_fifo_mode,
  input wire logic wrap_fifo_mode,
  input wire logic double_speed_mode,
  input wire logic line_pair_delay_mode,
  input wire logic delay_select,
  // Address clock steps, one-cycle enables at falling edges
  input wire logic read_clk_fall,
  input wire logic write_clk_fall,
  input wire logic shared_clk_fall,
  // Counter clears and write controls
  input wire logic read_counter_clear_n,
  input wire logic write_counter_clear_n,
  input wire logic common_counter_clear_n,
  input wire logic write_enable_n,
  input wire logic write_gate_n,
  // Decode pulses
  output logic write_wrap_pulse_n,
  output logic read_wrap_pulse_n,
  output logic tap_pulse_1_n,
  output logic tap_pulse_2_n,
  output logic tap_pulse_3_n,
  output logic tap_pulse_4_n,
  // Storage array controls
  output logic [ADDR_W-1:0] mem_read_addr,
  output logic [ADDR_W-1:0] mem_write_addr,
  output logic mem_write_strobe,
  output logic write_inhibited
);

  lmac_mode_t mode;
  logic shared_mode;
  logic rd_tick;
  logic wr_tick;
  logic rd_level_n;
  logic wr_level_n;
  logic clear_allow;
  logic rd_fire;
  logic wr_fire;
  logic write_ok;
  logic wr_advance;
  logic has_inhibit;
  logic [ADDR_W-1:0] inhibit_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_lead;
  logic [DEC_N-1:0] dec_on;
  logic [DEC_N-1:0] dec_n_reg;
  logic inhibit_reg;
  logic strobe_reg;
  logic [ADDR_W-1:0] rd_out_reg;
  logic [ADDR_W-1:0] wr_out_reg;

  // Mode from straps, delay line when no strap is set
  always_comb begin
    if (stretch_fifo_mode) begin
      mode = MODE_STRETCH;
    end else if (wrap_fifo_mode) begin
      mode = MODE_WRAP;
    end else if (double_speed_mode) begin
      mode = MODE_DOUBLE;
    end else if (line_pair_delay_mode) begin
      mode = MODE_PAIR;
    end else begin
      mode = MODE_DELAY;
    end
  end

  // Per-mode inhibit address and active decoders
  always_comb begin
    case (mode)
      MODE_STRETCH: begin
        has_inhibit = 1'b1;
        inhibit_addr = INHIBIT_STRETCH;
        dec_on = '0;
      end
      MODE_WRAP: begin
        has_inhibit = 1'b0;
        inhibit_addr = ADDR_TOP;
        dec_on = DEC_ON_WRAP;
      end
      MODE_DOUBLE: begin
        has_inhibit = 1'b1;
        inhibit_addr = INHIBIT_DOUBLE;
        dec_on = '0;
      end
      MODE_PAIR: begin
        has_inhibit = 1'b1;
        inhibit_addr = INHIBIT_PAIR;
        dec_on = DEC_ON_PAIR;
      end
      MODE_DELAY: begin
        has_inhibit = 1'b0;
        inhibit_addr = ADDR_TOP;
        dec_on = DEC_ON_DELAY;
      end
      default: begin
        has_inhibit = 1'b0;
        inhibit_addr = ADDR_TOP;
        dec_on = '0;
      end
    endcase
  end

  // Shared modes run both counters from the single clock
  assign shared_mode = (mode == MODE_PAIR) || (mode == MODE_DELAY);
  assign rd_tick = shared_mode ? shared_clk_fall : read_clk_fall;
  assign wr_tick = shared_mode ? shared_clk_fall : write_clk_fall;
  assign rd_level_n = shared_mode ? common_counter_clear_n
                                  : read_counter_clear_n;
  assign wr_level_n = shared_mode ? common_counter_clear_n
                                  : write_counter_clear_n;

  // Line-pair clears only while the gate is high
  assign clear_allow = (mode != MODE_PAIR) || write_gate_n;

  // Write qualifier: gate in line-pair, enable elsewhere
  assign write_ok = (mode == MODE_PAIR) ? !write_gate_n
                                        : !write_enable_n;

  // Inhibited counter freezes until the next clear
  assign wr_advance = !inhibit_reg &&
                      ((mode != MODE_PAIR) || !write_gate_n);

  // Clear edge catchers for each counter
  lmac_clear_catch u_rd_catch (
    .clk(clk),
    .resetn(resetn),
    .tick(rd_tick),
    .level_n(rd_level_n),
    .allow(clear_allow),
    .fire(rd_fire)
  );

  lmac_clear_catch u_wr_catch (
    .clk(clk),
    .resetn(resetn),
    .tick(wr_tick),
    .level_n(wr_level_n),
    .allow(clear_allow),
    .fire(wr_fire)
  );

  // Read and write address counters
  lmac_addr_counter u_rd_cnt (
    .clk(clk),
    .resetn(resetn),
    .tick(rd_tick),
    .advance(1'b1),
    .clear(rd_fire),
    .addr(rd_addr)
  );

  lmac_addr_counter u_wr_cnt (
    .clk(clk),
    .resetn(resetn),
    .tick(wr_tick),
    .advance(wr_advance),
    .clear(wr_fire),
    .addr(wr_addr)
  );

  // Write inhibit: set past the mode's inhibit address (1023 in line-pair), lifted by a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inhibit_reg <= 1'b0;
    end else if (wr_tick) begin
      if (wr_fire) begin
        inhibit_reg <= 1'b0;
      end else if (has_inhibit && wr_addr == inhibit_addr) begin
        inhibit_reg <= 1'b1;
      end
    end
  end

  // Write strobe and address to the array
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_reg <= 1'b0;
      wr_out_reg <= ADDR_ZERO;
    end else begin
      strobe_reg <= wr_tick && write_ok && !inhibit_reg;
      if (wr_tick) begin
        wr_out_reg <= wr_addr;
      end
    end
  end

  // Read lead of five when delay select is low in line-pair
  assign rd_lead = (mode == MODE_PAIR && !delay_select) ? SELECT_LOW_LEAD
                                                        : ADDR_ZERO;

  // Array reads the address counted in the previous cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_out_reg <= ADDR_ZERO;
    end else if (rd_tick) begin
      rd_out_reg <= rd_addr + rd_lead;
    end
  end

  // Decode latches, each caught one address before its target
  genvar g;
  generate
    for (g = 0; g < DEC_N; g++) begin : g_dec
      logic dec_tick;
      logic [ADDR_W-1:0] dec_src;
      assign dec_tick = DEC_SRC_WRITE[g] ? wr_tick : rd_tick;
      assign dec_src = DEC_SRC_WRITE[g] ? wr_addr : rd_addr;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          dec_n_reg[g] <= DEC_IDLE[g];
        end else if (dec_tick) begin
          dec_n_reg[g] <= !(dec_on[g] &&
                            (dec_src == DEC_LATCH_A[g] ||
                             dec_src == DEC_LATCH_B[g]));
        end
      end
    end
  endgenerate

  // Outputs straight from flip-flops
  assign write_wrap_pulse_n = dec_n_reg[DEC_WWRAP];
  assign read_wrap_pulse_n = dec_n_reg[DEC_RWRAP];
  assign tap_pulse_1_n = dec_n_reg[DEC_TAP1];
  assign tap_pulse_2_n = dec_n_reg[DEC_TAP2];
  assign tap_pulse_3_n = dec_n_reg[DEC_TAP3];
  assign tap_pulse_4_n = dec_n_reg[DEC_TAP4];
  assign mem_read_addr = rd_out_reg;
  assign mem_write_addr = wr_out_reg;
  assign mem_write_strobe = strobe_reg;
  assign write_inhibited = inhibit_reg;

  // Write wrap pulse follows write address 2046
  wrap_pulse_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_WRAP && wr_tick && wr_addr == 11'h7FE)
      |=> !write_wrap_pulse_n
  ) else $error("write wrap pulse missed");

  // Tap 2 first target
  tap2_first_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_DELAY && rd_tick && rd_addr == 11'h38C)
      |=> !tap_pulse_2_n
  ) else $error("tap 2 missed at 909");

  // Tap 2 second target
  tap2_second_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_DELAY && rd_tick && rd_addr == 11'h71A)
      |=> !tap_pulse_2_n
  ) else $error("tap 2 missed at 1819");

  // Tap 3 target
  tap3_target_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_DELAY && rd_tick && rd_addr == 11'h46D)
      |=> !tap_pulse_3_n
  ) else $error("tap 3 missed at 1134");

  // Tap 4 target
  tap4_target_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_DELAY && rd_tick && rd_addr == 11'h464)
      |=> !tap_pulse_4_n
  ) else $error("tap 4 missed at 1125");

  // Clear leaves the counters at zero
  clear_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd_fire || wr_fire) |=>
      ((!$past(rd_fire) || rd_addr == ADDR_ZERO) &&
       (!$past(wr_fire) || wr_addr == ADDR_ZERO))
  ) else $error("counter not zero after clear");

  // Read clear level at the last read step, tracked apart from the catcher
  logic rd_prev_low_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_prev_low_reg <= 1'b1;
    end else if (rd_tick) begin
      rd_prev_low_reg <= !rd_level_n;
    end
  end

  // Held-low clear does not fire again
  clear_once_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd_tick && rd_prev_low_reg) |-> !rd_fire
  ) else $error("clear fired twice");

  // High step then allowed low step clears the read counter
  clear_fire_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd_tick && clear_allow && !rd_prev_low_reg && !rd_level_n) |-> rd_fire
  ) else $error("read clear missed");

  // Inhibit blocks writes until a clear
  inhibit_block_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (inhibit_reg && !(wr_tick && wr_fire)) |=>
      (inhibit_reg && !mem_write_strobe)
  ) else $error("write through inhibit");

  // Inhibit set on the top stretch address
  inhibit_set_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_STRETCH && wr_tick && !wr_fire && wr_addr == ADDR_TOP)
      |=> inhibit_reg
  ) else $error("inhibit not set at 2047");

  // Line-pair writes only with the gate low
  pair_gate_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_PAIR && wr_tick && write_gate_n) |=> !mem_write_strobe
  ) else $error("write with gate high");

  // Wrap mode counter rolls over
  wrap_roll_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (mode == MODE_WRAP && rd_tick && rd_addr == ADDR_TOP)
      |=> rd_addr == ADDR_ZERO
  ) else $error("read counter no rollover");

  // Tap 3 pulse lasts one address cycle
  pulse_width_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!tap_pulse_3_n && rd_tick && rd_addr != 11'h46D) |=> tap_pulse_3_n
  ) else $error("tap 3 held too long");

endmodule // lmac_line_memory_ctrl

// [verif/lmac_video_src.sv]
`timescale 1ns/1ps
module lmac_video_src (
  // Clock
  input wire logic clk
);
  // Pin levels driven toward the controller
  logic rst_n = 1'b0;
  logic [3:0] mode = 4'h0;
  logic sel = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic sh = 1'b0;
  logic rcl = 1'b1;
  logic wcl = 1'b1;
  logic ccl = 1'b1;
  logic we = 1'b1;
  logic gt = 1'b1;

  // Straps and select move only while the controller sits in reset
  task automatic restart(input logic [3:0] m, input logic d);
    @(negedge clk);
    rst_n = 1'b0;
    mode = m;
    sel = d;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // One cycle of pin activity, changed just after the falling edge
  task automatic drive(input logic s, r, w, rc, wc, cc, e, g);
    @(negedge clk);
    sh = s;
    rd = r;
    wr = w;
    rcl = rc;
    wcl = wc;
    ccl = cc;
    we = e;
    gt = g;
  endtask
endmodule // lmac_video_src

// [verif/line_memory_address_control_tb_top.sv]
`timescale 1ns/1ps
module line_memory_address_control_tb_top;
  typedef struct {int k; int v; int a;} lmac_note_t;
  logic clk = 1'b0;
  logic [5:0] pl;
  logic [5:0] pl_q = 6'h3F;
  logic [6:0] ev;
  logic [10:0] ra;
  logic [10:0] wa;
  logic stb;
  logic inh_o;
  int rdo = 0;
  int wdo = 0;
  int fail_count = 0;
  int compares = 0;
  lmac_note_t notes[$];
  lmac_note_t n;
  int rc, wc, rord, word, lim;
  bit rp, wp, inh;
  logic [3:0] m;
  logic sel;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  lmac_video_src lmac_video_src_i (.clk(clk));
  lmac_line_memory_ctrl lmac_line_memory_ctrl_i (
    .clk(clk), .resetn(lmac_video_src_i.rst_n),
    .stretch_fifo_mode(lmac_video_src_i.mode[0]),
    .wrap_fifo_mode(lmac_video_src_i.mode[1]),
    .double_speed_mode(lmac_video_src_i.mode[2]),
    .line_pair_delay_mode(lmac_video_src_i.mode[3]),
    .delay_select(lmac_video_src_i.sel),
    .read_clk_fall(lmac_video_src_i.rd),
    .write_clk_fall(lmac_video_src_i.wr),
    .shared_clk_fall(lmac_video_src_i.sh),
    .read_counter_clear_n(lmac_video_src_i.rcl),
    .write_counter_clear_n(lmac_video_src_i.wcl),
    .common_counter_clear_n(lmac_video_src_i.ccl),
    .write_enable_n(lmac_video_src_i.we),
    .write_gate_n(lmac_video_src_i.gt),
    .write_wrap_pulse_n(pl[0]), .read_wrap_pulse_n(pl[1]),
    .tap_pulse_1_n(pl[2]), .tap_pulse_2_n(pl[3]),
    .tap_pulse_3_n(pl[4]), .tap_pulse_4_n(pl[5]),
    .mem_read_addr(ra), .mem_write_addr(wa),
    .mem_write_strobe(stb), .write_inhibited(inh_o)
  );

  // Compare and count
  task automatic check(string nm, int e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  // Read slot k latches at count c in the current mode
  function automatic bit hit(int k, int c);
    bit sm;
    sm = m[3] | (m == 4'h0);
    case (k)
      1: return m[1] && c == 2046;
      2: return sm && (c == 899 || c == 1809);
      3: return sm && (c == 908 || c == 1818);
      4: return m == 4'h0 && c == 1133;
      default: return m == 4'h0 && c == 1124;
    endcase
  endfunction

  // Step ordinals taken from the pins
  always @(posedge clk) begin
    rdo <= rdo + int'(lmac_video_src_i.rd | lmac_video_src_i.sh);
    wdo <= wdo + int'(lmac_video_src_i.wr | lmac_video_src_i.sh);
  end

  // Pulse falls and strobes matched against the oldest note
  always @(negedge clk) begin
    ev = {stb, pl_q & ~pl};
    pl_q = pl;
    for (int k = 0; k < 7; k++) begin
      if (ev[k] === 1'b1 && notes.size() == 0) begin
        check("unexpected event", -1, k);
      end else if (ev[k] === 1'b1) begin
        n = notes.pop_front();
        check("event kind", n.k, k);
        if (k == 6) begin
          check("write address", n.v, 32'(wa));
        end else if (k == 0) begin
          check("write step", n.v, wdo);
        end else begin
          check("read step", n.v, rdo);
          check("read address", n.a, 32'(ra));
        end
      end
    end
  end

  // One step of both sides with its expected results noted
  task automatic step(bit r, bit w, bit rl, bit wl, bit e, bit g);
    bit sm, rf, wf, ws;
    sm = m[3] | (m == 4'h0);
    ws = sm ? r : w;
    wl = sm ? rl : wl;
    lmac_video_src_i.drive(sm & r, !sm & r, !sm & w, sm | rl, sm | wl,
                           !sm | rl, e, g);
    if (ws) begin
      word++;
      wf = !wl && wp && (!m[3] || g);
      wp = wl;
      if (m[1] && wc == 2046) note_it(0, word, 0);
    end
    if (r) begin
      rord++;
      rf = !rl && rp && (!m[3] || g);
      rp = rl;
      for (int k = 1; k < 6; k++) begin
        if (hit(k, rc)) note_it(k, rord, rc + ((m[3] && !sel) ? 5 : 0));
      end
      rc = rf ? 0 : (rc + 1) % 2048;
    end
    if (ws && wf) begin
      wc = 0;
      inh = 0;
    end else if (ws && !inh) begin
      if (m[3] ? !g : !e) note_it(6, wc, 0);
      if (wc == lim) inh = 1;
      else if (!m[3] || !g) wc = (wc + 1) % 2048;
    end
  endtask

  task automatic note_it(int k, int v, int a);
    notes.push_back('{k, v, a});
  endtask

  // Let results land, then nothing may remain pending
  task automatic drain();
    repeat (3) step(0, 0, 1, 1, 1, 1);
    check("pending notes", 0, notes.size());
    check("write inhibit", inh, inh_o);
  endtask

  // One mode: clear, random traffic, then inhibit release
  task automatic run(logic [3:0] md, logic d, int cnt);
    bit r, w, e, g, wl, done;
    m = md;
    sel = d;
    lim = (md[0] | md[2]) ? 2047 : md[3] ? 1023 : -1;
    {rc, wc, rp, wp, inh, done} = '0;
    lmac_video_src_i.restart(md, d);
    if (md[3]) step(1, 1, 1, 1, 1, 1);
    if (md[3]) step(1, 1, 0, 0, 1, 0);
    step(1, 1, 1, 1, 1, 1);
    step(1, 1, 0, 0, 1, 1);
    step(1, 1, 0, 0, 1, 1);
    repeat (cnt) begin
      r = $urandom % 5 != 0;
      w = $urandom % 5 != 0;
      e = $urandom % 4 == 0;
      g = $urandom % 4 == 0;
      wl = !(md[1] && wc == 2046 && !done && w);
      e = e | !wl;
      done = done | !wl;
      step(r, w, 1, wl, e, g);
    end
    drain();
    step(1, 0, 0, 1, 1, 1);
    drain();
    step(0, 1, 1, 0, 1, 1);
    step(1, 1, 1, 1, 0, 0);
    drain();
  endtask

  initial begin
    void'($urandom(32'h394B));
    run(4'h2, 1'b1, 5400);
    run(4'h1, 1'b1, 3000);
    run(4'h4, 1'b1, 3000);
    run(4'h8, 1'b0, 3000);
    run(4'h8, 1'b1, 3000);
    run(4'h0, 1'b1, 3000);
    test_done();
  end

  // Verdict
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // line_memory_address_control_tb_top
